// ---- logic/usbecr_regs.sv ----
// usbecr_regs: endpoint configuration registers of a full-speed usb function
// assumes an axi4-lite master on ref_clk_i and a packet engine on the same clock
`timescale 1ns/1ps
module usbecr_regs (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [usbecr_pkg::AW-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [usbecr_pkg::AW-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic sof_valid_i,
   input wire logic [10:0] sof_frame_i,
   input wire logic set_addr_valid_i,
   input wire logic [6:0] set_addr_i,
   input wire logic setup_valid_i,
   input wire logic [63:0] setup_data_i,
   input wire logic tog_flip_i,
   input wire logic [2:0] tog_flip_ep_i,
   input wire logic tog_flip_in_i,
   input wire logic tok_valid_i,
   input wire logic [6:0] tok_addr_i,
   input wire logic [3:0] tok_ep_i,
   input wire logic tok_in_i,
   input wire logic iso_in_empty_i,
   output logic tok_done_o,
   output logic tok_respond_o,
   output logic tok_zero_len_o,
   output logic [3:0] tok_ep_eff_o,
   output logic [5:0] iso_out_buffer_start_o,
   output logic [5:0] iso_in_buffer_start_o
);
   typedef struct packed {
      logic aw_have;
      logic [15:0] aw_idx;
      logic w_have;
      logic [7:0] w_data;
      logic w_lane0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
      logic sel_in;
      logic [2:0] sel_ep;
      logic [5:0] tog_in;
      logic [5:0] tog_out;
      logic [9:0] frame;
      logic [6:0] fn_addr;
      logic [7:0] pair;
      logic [5:1] in_act;
      logic [5:1] out_act;
      logic iso_in_act;
      logic iso_out_act;
      logic [63:0] setup;
      logic [5:0] iso_out_start;
      logic [5:0] iso_in_start;
   } usbecr_st_t;

   usbecr_st_t s_r;
   usbecr_st_t s_nxt;
   logic wr_go;
   logic rd_go;
   logic [15:0] ridx;

   // toggle of endpoint ep; codes above five have none and read zero
   function automatic logic tog_pick(input logic [5:0] t, input logic [2:0] ep);
      tog_pick = (ep <= usbecr_pkg::EP_MAX) ? t[ep] : 1'b0;
   endfunction

   function automatic logic is_mapped(input logic [15:0] idx);
      is_mapped = (idx >= usbecr_pkg::IDX_TOG && idx <= usbecr_pkg::IDX_ISO_OUT
                   && idx != 16'hC7DA && idx != 16'hC7DC)
                  || (idx >= usbecr_pkg::IDX_SETUP_LO && idx <= usbecr_pkg::IDX_SETUP_HI)
                  || idx == usbecr_pkg::IDX_ISO_OUT_START
                  || idx == usbecr_pkg::IDX_ISO_IN_START;
   endfunction

   always_comb begin
      s_nxt = s_r;
      wr_go = s_r.aw_have && s_r.w_have && !s_r.bvalid;
      rd_go = s_axi_arvalid_i && s_r.arready;
      ridx = s_axi_araddr_i[usbecr_pkg::AW-1:2];
      // address and data are taken independently, held until the write is done
      if (s_axi_awvalid_i && s_r.awready) begin
         s_nxt.aw_have = 1'b1;
         s_nxt.aw_idx = s_axi_awaddr_i[usbecr_pkg::AW-1:2];
      end
      if (s_axi_wvalid_i && s_r.wready) begin
         s_nxt.w_have = 1'b1;
         s_nxt.w_data = s_axi_wdata_i[7:0];
         s_nxt.w_lane0 = s_axi_wstrb_i[0];
      end
      if (s_r.bvalid && s_axi_bready_i) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.rvalid && s_axi_rready_i) begin
         s_nxt.rvalid = 1'b0;
      end
      if (sof_valid_i) begin
         s_nxt.frame = sof_frame_i[usbecr_pkg::FW-1:0];
      end
      if (set_addr_valid_i) begin
         s_nxt.fn_addr = set_addr_i;
      end
      if (setup_valid_i) begin
         s_nxt.setup = setup_data_i;
      end
      // engine flips a toggle after a good transaction; a software force below wins
      if (tog_flip_i && tog_flip_ep_i <= usbecr_pkg::EP_MAX) begin
         if (tog_flip_in_i) begin
            s_nxt.tog_in[tog_flip_ep_i] = ~s_r.tog_in[tog_flip_ep_i];
         end else begin
            s_nxt.tog_out[tog_flip_ep_i] = ~s_r.tog_out[tog_flip_ep_i];
         end
      end
      if (wr_go) begin
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = is_mapped(s_r.aw_idx) ? usbecr_pkg::RESP_OK : usbecr_pkg::RESP_DEC;
         // writes without lane 0 change nothing; read-only registers ignore writes
         if (s_r.w_lane0) begin
            case (s_r.aw_idx)
               usbecr_pkg::IDX_TOG: begin
                  s_nxt.sel_in = s_r.w_data[usbecr_pkg::TOG_IO];
                  s_nxt.sel_ep = s_r.w_data[2:0];
                  if (s_r.w_data[2:0] <= usbecr_pkg::EP_MAX) begin
                     if (s_r.w_data[usbecr_pkg::TOG_SET]) begin
                        if (s_r.w_data[usbecr_pkg::TOG_IO]) begin
                           s_nxt.tog_in[s_r.w_data[2:0]] = 1'b1;
                        end else begin
                           s_nxt.tog_out[s_r.w_data[2:0]] = 1'b1;
                        end
                     end else if (s_r.w_data[usbecr_pkg::TOG_CLR]) begin
                        if (s_r.w_data[usbecr_pkg::TOG_IO]) begin
                           s_nxt.tog_in[s_r.w_data[2:0]] = 1'b0;
                        end else begin
                           s_nxt.tog_out[s_r.w_data[2:0]] = 1'b0;
                        end
                     end
                  end
               end
               usbecr_pkg::IDX_PAIR: s_nxt.pair = s_r.w_data & usbecr_pkg::PAIR_MASK;
               usbecr_pkg::IDX_BULK_IN: s_nxt.in_act = s_r.w_data[5:1];
               usbecr_pkg::IDX_BULK_OUT: s_nxt.out_act = s_r.w_data[5:1];
               usbecr_pkg::IDX_ISO_IN: s_nxt.iso_in_act = s_r.w_data[0];
               usbecr_pkg::IDX_ISO_OUT: s_nxt.iso_out_act = s_r.w_data[0];
               usbecr_pkg::IDX_ISO_OUT_START: s_nxt.iso_out_start = s_r.w_data[7:2];
               usbecr_pkg::IDX_ISO_IN_START: s_nxt.iso_in_start = s_r.w_data[7:2];
               default: ;
            endcase
         end
      end
      if (rd_go) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = is_mapped(ridx) ? usbecr_pkg::RESP_OK : usbecr_pkg::RESP_DEC;
         s_nxt.rdata = 8'h00;
         case (ridx)
            usbecr_pkg::IDX_TOG: s_nxt.rdata = {
               tog_pick(s_r.sel_in ? s_r.tog_in : s_r.tog_out, s_r.sel_ep),
               2'b00, s_r.sel_in, 1'b0, s_r.sel_ep};
            usbecr_pkg::IDX_FRM_LO: s_nxt.rdata = s_r.frame[7:0];
            usbecr_pkg::IDX_FRM_HI: s_nxt.rdata = {6'h00, s_r.frame[9:8]};
            usbecr_pkg::IDX_FNADDR: s_nxt.rdata = {1'b0, s_r.fn_addr};
            usbecr_pkg::IDX_PAIR: s_nxt.rdata = s_r.pair;
            usbecr_pkg::IDX_BULK_IN: s_nxt.rdata = {2'b00, s_r.in_act, 1'b1};
            usbecr_pkg::IDX_BULK_OUT: s_nxt.rdata = {2'b00, s_r.out_act, 1'b1};
            usbecr_pkg::IDX_ISO_IN: s_nxt.rdata = {7'h00, s_r.iso_in_act};
            usbecr_pkg::IDX_ISO_OUT: s_nxt.rdata = {7'h00, s_r.iso_out_act};
            usbecr_pkg::IDX_ISO_OUT_START: s_nxt.rdata = {s_r.iso_out_start, 2'b00};
            usbecr_pkg::IDX_ISO_IN_START: s_nxt.rdata = {s_r.iso_in_start, 2'b00};
            default: begin
               if (ridx >= usbecr_pkg::IDX_SETUP_LO && ridx <= usbecr_pkg::IDX_SETUP_HI) begin
                  s_nxt.rdata = s_r.setup[{ridx[2:0], 3'b000} +: 8];
               end
            end
         endcase
      end
      // at most one write held and one read in flight; the next write can be taken while a response waits
      s_nxt.awready = !s_nxt.aw_have;
      s_nxt.wready = !s_nxt.w_have;
      s_nxt.arready = !s_nxt.rvalid;
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.awready <= 1'b1;
         s_r.wready <= 1'b1;
         s_r.arready <= 1'b1;
         s_r.fn_addr <= usbecr_pkg::RST_FNADDR;
         s_r.pair <= usbecr_pkg::RST_PAIR;
         s_r.in_act <= usbecr_pkg::RST_ACT;
         s_r.out_act <= usbecr_pkg::RST_ACT;
         s_r.iso_out_start <= usbecr_pkg::RST_START;
         s_r.iso_in_start <= usbecr_pkg::RST_START;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_awready_o = s_r.awready;
   assign s_axi_wready_o = s_r.wready;
   assign s_axi_bvalid_o = s_r.bvalid;
   assign s_axi_bresp_o = s_r.bresp;
   assign s_axi_arready_o = s_r.arready;
   assign s_axi_rvalid_o = s_r.rvalid;
   assign s_axi_rresp_o = s_r.rresp;
   assign s_axi_rdata_o = {24'h000000, s_r.rdata};
   assign iso_out_buffer_start_o = s_r.iso_out_start;
   assign iso_in_buffer_start_o = s_r.iso_in_start;

   usbecr_cfg_if cfg ();
   assign cfg.fn_addr = s_r.fn_addr;
   assign cfg.in_act = s_r.in_act;
   assign cfg.out_act = s_r.out_act;
   assign cfg.iso_in_act = s_r.iso_in_act;
   assign cfg.iso_out_act = s_r.iso_out_act;
   assign cfg.pair = s_r.pair[4:0];
   assign cfg.zero_len_on_empty = s_r.pair[usbecr_pkg::ZLEN];

   usbecr_tok u_tok (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .cfg(cfg.snk),
      .tok_valid_i(tok_valid_i),
      .tok_addr_i(tok_addr_i),
      .tok_ep_i(tok_ep_i),
      .tok_in_i(tok_in_i),
      .iso_in_empty_i(iso_in_empty_i),
      .done_o(tok_done_o),
      .respond_o(tok_respond_o),
      .zero_len_o(tok_zero_len_o),
      .ep_eff_o(tok_ep_eff_o)
   );

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_tog_wr;
      wr_go && s_r.w_lane0 && s_r.aw_idx == usbecr_pkg::IDX_TOG && s_r.w_data[2:0] <= 3'h5;
   endsequence

   tog_read_a: assert property (
      rd_go && ridx == usbecr_pkg::IDX_TOG
      |=> s_axi_rvalid_o && s_axi_rdata_o[7] ==
          $past(tog_pick(s_r.sel_in ? s_r.tog_in : s_r.tog_out, s_r.sel_ep)))
      else $error("toggle readback does not match selected endpoint");
   tog_set_a: assert property (
      s_tog_wr ##0 s_r.w_data[6] && s_r.w_data[4]
      |=> s_r.tog_in[$past(s_r.w_data[2:0])] && s_r.sel_in)
      else $error("set strobe did not force DATA1");
   tog_clr_a: assert property (
      s_tog_wr ##0 !s_r.w_data[6] && s_r.w_data[5] && !s_r.w_data[4]
      |=> !s_r.tog_out[$past(s_r.w_data[2:0])] && s_axi_bvalid_o)
      else $error("reset strobe did not force DATA0");
   tog_hold_a: assert property (
      s_tog_wr ##0 s_r.w_data[6:5] == 2'b00 && !tog_flip_i
      |=> $stable(s_r.tog_in) && $stable(s_r.tog_out))
      else $error("toggle changed without a strobe bit");
   frame_cap_a: assert property (
      sof_valid_i |=> s_r.frame == $past(sof_frame_i[9:0]))
      else $error("frame number not captured at sof");
   addr_cap_a: assert property (
      set_addr_valid_i |=> s_r.fn_addr == $past(set_addr_i) && cfg.fn_addr == $past(set_addr_i))
      else $error("function address not captured");
   setup_cap_a: assert property (
      setup_valid_i |=> s_r.setup == $past(setup_data_i))
      else $error("setup packet not stored");
   act_fixed_a: assert property (
      rd_go && ridx == usbecr_pkg::IDX_BULK_IN
      |=> s_axi_rdata_o[0] && s_axi_rdata_o[7:6] == 2'b00)
      else $error("in active register fixed bits wrong");
   start_pad_a: assert property (
      rd_go && (ridx == usbecr_pkg::IDX_ISO_OUT_START || ridx == usbecr_pkg::IDX_ISO_IN_START)
      |=> s_axi_rdata_o[1:0] == 2'b00)
      else $error("start address low bits not zero");
endmodule

// ---- logic/usbecr_pkg.sv ----
// usbecr_pkg: constants of the usb endpoint configuration register block
// assumes 32-bit axi4-lite data with each 8-bit register in the low byte lane
package usbecr_pkg;
   localparam int AW = 18;
   localparam int IW = 16;
   localparam int FW = 10;
   localparam int NEP = 6;
   // register indexes; byte address is four times the index
   localparam logic [15:0] IDX_TOG = 16'hC7D7;
   localparam logic [15:0] IDX_FRM_LO = 16'hC7D8;
   localparam logic [15:0] IDX_FRM_HI = 16'hC7D9;
   localparam logic [15:0] IDX_FNADDR = 16'hC7DB;
   localparam logic [15:0] IDX_PAIR = 16'hC7DD;
   localparam logic [15:0] IDX_BULK_IN = 16'hC7DE;
   localparam logic [15:0] IDX_BULK_OUT = 16'hC7DF;
   localparam logic [15:0] IDX_ISO_IN = 16'hC7E0;
   localparam logic [15:0] IDX_ISO_OUT = 16'hC7E1;
   localparam logic [15:0] IDX_SETUP_LO = 16'hC7E8;
   localparam logic [15:0] IDX_SETUP_HI = 16'hC7EF;
   localparam logic [15:0] IDX_ISO_OUT_START = 16'hC7F0;
   localparam logic [15:0] IDX_ISO_IN_START = 16'hC7F8;
   // toggle control and pairing field positions, highest toggle endpoint and iso endpoint code
   localparam int TOG_VAL = 7;
   localparam int TOG_SET = 6;
   localparam int TOG_CLR = 5;
   localparam int TOG_IO = 4;
   localparam int ZLEN = 7;
   localparam logic [7:0] PAIR_MASK = 8'h9F;
   localparam logic [2:0] EP_MAX = 3'h5;
   localparam logic [3:0] EP_ISO = 4'h8;
   // reset values and axi response codes
   localparam logic [7:0] RST_PAIR = 8'h00;
   localparam logic [6:0] RST_FNADDR = 7'h00;
   localparam logic [4:0] RST_ACT = 5'h00;
   localparam logic [5:0] RST_START = 6'h00;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_DEC = 2'h3;
endpackage

// ---- logic/usbecr_cfg_if.sv ----
// usbecr_cfg_if: configuration handed from the register file to the token filter
// assumes both ends run on the same clock; all signals are plain levels
`timescale 1ns/1ps
interface usbecr_cfg_if;
   logic [6:0] fn_addr;
   logic [5:1] in_act;
   logic [5:1] out_act;
   logic iso_in_act;
   logic iso_out_act;
   logic [4:0] pair;
   logic zero_len_on_empty;
   modport src (output fn_addr, in_act, out_act, iso_in_act, iso_out_act, pair,
      zero_len_on_empty);
   modport snk (input fn_addr, in_act, out_act, iso_in_act, iso_out_act, pair,
      zero_len_on_empty);
endinterface

// ---- logic/usbecr_tok.sv ----
// usbecr_tok: decides whether a decoded token is answered and on which endpoint
// assumes tokens arrive as one-cycle strobes from the packet engine
`timescale 1ns/1ps
module usbecr_tok (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   usbecr_cfg_if.snk cfg,
   input wire logic tok_valid_i,
   input wire logic [6:0] tok_addr_i,
   input wire logic [3:0] tok_ep_i,
   input wire logic tok_in_i,
   input wire logic iso_in_empty_i,
   output logic done_o,
   output logic respond_o,
   output logic zero_len_o,
   output logic [3:0] ep_eff_o
);
   typedef struct packed {
      logic done;
      logic respond;
      logic zero_len;
      logic [3:0] ep_eff;
   } usbecr_tok_st_t;

   usbecr_tok_st_t s_r;
   usbecr_tok_st_t s_nxt;
   logic act;
   logic hit;
   logic starve;

   always_comb begin
      s_nxt = s_r;
      s_nxt.done = tok_valid_i;
      // endpoint active bits; 0, 6 and 7 have no enable
      unique case (tok_ep_i)
         4'h0, 4'h6, 4'h7: act = 1'b1;
         4'h1, 4'h2, 4'h3, 4'h4, 4'h5:
            act = tok_in_i ? cfg.in_act[tok_ep_i[2:0]] : cfg.out_act[tok_ep_i[2:0]];
         usbecr_pkg::EP_ISO: act = tok_in_i ? cfg.iso_in_act : cfg.iso_out_act;
         default: act = 1'b0;
      endcase
      hit = tok_valid_i && (tok_addr_i == cfg.fn_addr) && act;
      starve = tok_in_i && (tok_ep_i == usbecr_pkg::EP_ISO) && iso_in_empty_i;
      s_nxt.respond = hit && (!starve || cfg.zero_len_on_empty);
      s_nxt.zero_len = hit && starve && cfg.zero_len_on_empty;
      s_nxt.ep_eff = tok_ep_i;
      if (tok_in_i) begin
         if ((tok_ep_i == 4'h3 && cfg.pair[0]) || (tok_ep_i == 4'h5 && cfg.pair[1])
               || (tok_ep_i == 4'h7 && cfg.pair[2])) begin
            s_nxt.ep_eff = {tok_ep_i[3:1], 1'b0};
         end
      end else if ((tok_ep_i == 4'h3 && cfg.pair[3]) || (tok_ep_i == 4'h5 && cfg.pair[4])) begin
         s_nxt.ep_eff = {tok_ep_i[3:1], 1'b0};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign done_o = s_r.done;
   assign respond_o = s_r.respond;
   assign zero_len_o = s_r.zero_len;
   assign ep_eff_o = s_r.ep_eff;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   tok_addr_a: assert property (
      tok_valid_i && tok_addr_i != cfg.fn_addr |=> done_o && !respond_o)
      else $error("token for another address was answered");
   iso_zlen_a: assert property (
      tok_valid_i && tok_in_i && tok_ep_i == usbecr_pkg::EP_ISO && iso_in_empty_i
      |=> (zero_len_o == respond_o) && (respond_o == $past(hit && cfg.zero_len_on_empty)))
      else $error("empty iso in reply wrong");
   iso_gate_a: assert property (
      tok_valid_i && tok_in_i && tok_ep_i == usbecr_pkg::EP_ISO && !cfg.iso_in_act
      |=> !respond_o)
      else $error("disabled iso in endpoint answered");
   pair_map_a: assert property (
      tok_valid_i && tok_in_i && tok_ep_i == 4'h3 && cfg.pair[0] |=> ep_eff_o == 4'h2)
      else $error("paired in 3 not merged into in 2");
endmodule

// ---- bench/usbecr_host.sv ----
// usbecr_host: behavioural packet engine standing for the usb host side
// assumes the register block shares ref_clk_i; every strobe lasts one cycle
`timescale 1ns/1ps
module usbecr_host (
   input wire logic ref_clk_i,
   input wire logic done_i,
   input wire logic respond_i,
   input wire logic zero_len_i,
   input wire logic [3:0] ep_eff_i,
   output logic sof_valid_o,
   output logic [10:0] sof_frame_o,
   output logic set_addr_valid_o,
   output logic [6:0] set_addr_o,
   output logic setup_valid_o,
   output logic [63:0] setup_data_o,
   output logic tok_valid_o,
   output logic [6:0] tok_addr_o,
   output logic [3:0] tok_ep_o,
   output logic tok_in_o,
   output logic iso_in_empty_o
);
   // fields outside a strobe carry junk, except iso_in_empty_o which keeps its last value, so stale values are never relied on
   initial begin
      sof_valid_o = 1'b0;
      set_addr_valid_o = 1'b0;
      setup_valid_o = 1'b0;
      tok_valid_o = 1'b0;
      {sof_frame_o, set_addr_o, setup_data_o} = '1;
      {tok_addr_o, tok_ep_o, tok_in_o, iso_in_empty_o} = '1;
   end
   task automatic sof(input logic [10:0] f);
      sof_frame_o <= f;
      sof_valid_o <= 1'b1;
      @(posedge ref_clk_i);
      sof_valid_o <= 1'b0;
      sof_frame_o <= ~f;
   endtask
   // address assignment and setup packet arrive together in one strobe
   task automatic ctl(input logic [6:0] a, input logic [63:0] d);
      {set_addr_o, setup_data_o} <= {a, d};
      {set_addr_valid_o, setup_valid_o} <= 2'h3;
      @(posedge ref_clk_i);
      {set_addr_valid_o, setup_valid_o} <= 2'h0;
      {set_addr_o, setup_data_o} <= ~{a, d};
   endtask
   task automatic tok(input logic [6:0] a, input logic [3:0] e, input logic i,
         input logic m, output logic [7:0] v);
      {tok_addr_o, tok_ep_o, tok_in_o, iso_in_empty_o} <= {a, e, i, m};
      tok_valid_o <= 1'b1;
      @(posedge ref_clk_i);
      tok_valid_o <= 1'b0;
      {tok_addr_o, tok_ep_o, tok_in_o} <= ~{a, e, i};
      @(negedge ref_clk_i);
      v = {done_i, respond_i, zero_len_i, 1'b0, respond_i ? ep_eff_i : 4'h0};
      @(posedge ref_clk_i);
   endtask
endmodule

// ---- bench/usbecr_regs_tb.sv ----
// usbecr_regs_tb: self-checking bench for the endpoint configuration registers
// assumes usbecr_host drives the usb side; wstrb and tog_flip come from the bench
`timescale 1ns/1ps
module usbecr_regs_tb;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [17:0] awa = '0;
   logic [17:0] ara = '0;
   logic [31:0] wd = '0;
   logic [31:0] rdt;
   logic awv = 1'b0;
   logic wv = 1'b0;
   logic arv = 1'b0;
   logic br = 1'b0;
   logic rr = 1'b0;
   logic tf = 1'b0;
   logic tfi = 1'b0;
   logic [2:0] tfe = '0;
   logic [3:0] ws = 4'hF;
   logic awr, wrd, bv, arr, rv, sv, av, uv, tv, ti, em, dn, rs, zl;
   logic [1:0] bre, rre;
   logic [10:0] sf;
   logic [6:0] ad, ta;
   logic [63:0] ud;
   logic [3:0] te, ee;
   logic [5:0] os, is;
   logic [7:0] rdv, rsp, v;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;
   usbecr_regs usbecr_regs_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
      .s_axi_bresp_o(bre), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
      .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdt), .s_axi_rresp_o(rre), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
      .sof_valid_i(sv), .sof_frame_i(sf), .set_addr_valid_i(av), .set_addr_i(ad),
      .setup_valid_i(uv), .setup_data_i(ud), .tog_flip_i(tf), .tog_flip_ep_i(tfe),
      .tog_flip_in_i(tfi), .tok_valid_i(tv), .tok_addr_i(ta), .tok_ep_i(te),
      .tok_in_i(ti), .iso_in_empty_i(em), .tok_done_o(dn), .tok_respond_o(rs),
      .tok_zero_len_o(zl), .tok_ep_eff_o(ee), .iso_out_buffer_start_o(os),
      .iso_in_buffer_start_o(is));
   usbecr_host usbecr_host_i (.ref_clk_i(ref_clk_i), .done_i(dn), .respond_i(rs),
      .zero_len_i(zl), .ep_eff_i(ee), .sof_valid_o(sv), .sof_frame_o(sf),
      .set_addr_valid_o(av), .set_addr_o(ad), .setup_valid_o(uv), .setup_data_o(ud),
      .tok_valid_o(tv), .tok_addr_o(ta), .tok_ep_o(te), .tok_in_o(ti),
      .iso_in_empty_o(em));
   initial begin
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   task automatic results();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // ready is a register, so its value at the falling edge is the one taken
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic aw;
      logic w;
      {aw, w} = 2'h3;
      {awa, wd} <= {a, 2'h0, 24'h0, d};
      {awv, wv} <= 2'h3;
      while (aw || w) begin
         @(negedge ref_clk_i);
         if (awr === 1'b1) aw = 1'b0;
         if (wrd === 1'b1) w = 1'b0;
         @(posedge ref_clk_i);
         {awv, wv} <= {aw, w};
      end
      br <= 1'b1;
      @(negedge ref_clk_i);
      while (bv !== 1'b1) @(negedge ref_clk_i);
      rsp = {6'h0, bre};
      @(posedge ref_clk_i);
      br <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a);
      ara <= {a, 2'h0};
      arv <= 1'b1;
      @(negedge ref_clk_i);
      while (arr !== 1'b1) @(negedge ref_clk_i);
      @(posedge ref_clk_i);
      arv <= 1'b0;
      rr <= 1'b1;
      @(negedge ref_clk_i);
      while (rv !== 1'b1) @(negedge ref_clk_i);
      {rdv, rsp} = {rdt[7:0], 6'h0, rre};
      @(posedge ref_clk_i);
      rr <= 1'b0;
   endtask
   task automatic rc(input string n, input logic [15:0] a, input logic [7:0] e);
      rd(a);
      chk(n, e, rdv);
   endtask
   task automatic t_toggle();
      logic [7:0] s;
      rc("bulk in reset", 16'hC7DE, 8'h01);
      for (int i = 0; i < 12; i++) begin
         s = {3'h0, i[0], 1'h0, i[3:1]};
         wr(16'hC7D7, s | 8'h40);
         rc("toggle set", 16'hC7D7, s | 8'h80);
         wr(16'hC7D7, s);
         rc("toggle held", 16'hC7D7, s | 8'h80);
         wr(16'hC7D7, s | 8'h20);
         rc("toggle cleared", 16'hC7D7, s);
      end
      wr(16'hC7D7, 8'h41);
      wr(16'hC7D7, 8'h11);
      rc("in 1 untouched", 16'hC7D7, 8'h11);
      // the packet engine flips in 3 after a good transaction
      tfe <= 3'h3;
      tfi <= 1'b1;
      tf <= 1'b1;
      @(posedge ref_clk_i);
      tf <= 1'b0;
      wr(16'hC7D7, 8'h13);
      rc("engine flip", 16'hC7D7, 8'h93);
   endtask
   task automatic t_frame();
      usbecr_host_i.sof(11'h3FF);
      rc("frame low", 16'hC7D8, 8'hFF);
      rc("frame high", 16'hC7D9, 8'h03);
      usbecr_host_i.sof(11'h400);
      wr(16'hC7D8, 8'h5A);
      rc("frame wrap low", 16'hC7D8, 8'h00);
      rc("frame wrap high", 16'hC7D9, 8'h00);
   endtask
   task automatic t_addr();
      logic [63:0] d;
      d = 64'hF7E6D5C4B3A29180;
      usbecr_host_i.ctl(7'h7F, d);
      wr(16'hC7DB, 8'h11);
      rc("function address", 16'hC7DB, 8'h7F);
      for (int k = 0; k < 8; k++) rc("setup byte", 16'hC7E8 + 16'(k), d[8*k +: 8]);
      usbecr_host_i.tok(7'h7F, 4'h0, 1'b1, 1'b0, v);
      chk("own address", 8'hC0, v);
      usbecr_host_i.tok(7'h7E, 4'h0, 1'b1, 1'b0, v);
      chk("other address", 8'h80, v);
   endtask
   task automatic t_active();
      wr(16'hC7DE, 8'hFF);
      rc("bulk in all", 16'hC7DE, 8'h3F);
      usbecr_host_i.tok(7'h7F, 4'h5, 1'b1, 1'b0, v);
      chk("in 5 active", 8'hC5, v);
      wr(16'hC7DE, 8'h1E);
      usbecr_host_i.tok(7'h7F, 4'h5, 1'b1, 1'b0, v);
      chk("in 5 inactive", 8'h80, v);
      usbecr_host_i.tok(7'h7F, 4'h5, 1'b0, 1'b0, v);
      chk("out 5 inactive", 8'h80, v);
      wr(16'hC7DF, 8'hBE);
      rc("bulk out", 16'hC7DF, 8'h3F);
      usbecr_host_i.tok(7'h7F, 4'h5, 1'b0, 1'b0, v);
      chk("out 5 active", 8'hC5, v);
   endtask
   task automatic t_iso();
      wr(16'hC7E0, 8'hFF);
      rc("iso in enable", 16'hC7E0, 8'h01);
      usbecr_host_i.tok(7'h7F, 4'h8, 1'b1, 1'b1, v);
      chk("iso empty silent", 8'h80, v);
      wr(16'hC7DD, 8'h80);
      usbecr_host_i.tok(7'h7F, 4'h8, 1'b1, 1'b1, v);
      chk("iso zero length", 8'hE8, v);
      usbecr_host_i.tok(7'h7F, 4'h8, 1'b0, 1'b0, v);
      chk("iso out off", 8'h80, v);
      wr(16'hC7E1, 8'h03);
      rc("iso out enable", 16'hC7E1, 8'h01);
      usbecr_host_i.tok(7'h7F, 4'h8, 1'b0, 1'b0, v);
      chk("iso out on", 8'hC8, v);
      wr(16'hC7E0, 8'h00);
      usbecr_host_i.tok(7'h7F, 4'h8, 1'b1, 1'b0, v);
      chk("iso in off", 8'h80, v);
   endtask
   task automatic t_pair();
      int j;
      wr(16'hC7DE, 8'h3E);
      wr(16'hC7DD, 8'hFF);
      rc("pairing", 16'hC7DD, 8'h9F);
      for (int i = 0; i < 5; i++) begin
         j = (i < 3) ? i : i - 3;
         usbecr_host_i.tok(7'h7F, 4'(2 * j + 3), i < 3, 1'b0, v);
         chk("paired endpoint", 8'(8'hC2 + 2 * j), v);
      end
      wr(16'hC7DD, 8'h9E);
      usbecr_host_i.tok(7'h7F, 4'h3, 1'b1, 1'b0, v);
      chk("unpaired in 3", 8'hC3, v);
   endtask
   task automatic t_start();
      wr(16'hC7F0, 8'hFF);
      rc("iso out start", 16'hC7F0, 8'hFC);
      chk("iso out start pins", 8'h3F, {2'h0, os});
      // a write without lane 0 must leave the register alone
      ws <= 4'h0;
      wr(16'hC7F0, 8'h00);
      ws <= 4'hF;
      rc("iso out start no lane", 16'hC7F0, 8'hFC);
      wr(16'hC7F8, 8'hA7);
      rc("iso in start", 16'hC7F8, 8'hA4);
      chk("iso in start pins", 8'h29, {2'h0, is});
      rd(16'hC7DA);
      chk("unmapped read", 8'h03, rsp);
      wr(16'hC7DC, 8'h01);
      chk("unmapped write", 8'h03, rsp);
   endtask
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 6000) begin
         failures++;
         results();
      end
   end
   initial begin
      repeat (5) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      t_toggle();
      t_frame();
      t_addr();
      t_active();
      t_iso();
      t_pair();
      t_start();
      results();
   end
endmodule
